// file: hdl/gp_counter.sv
// General-purpose 24-bit counter with pulse, train, shift and capture modes
`timescale 1ns/1ns
`include "gpc_cfg.svh"
// How it works
// [R1] Count registers take any 24-bit value
// [R2] Fast timebase, one tick per clock
// [R3] Slow timebase ticks every 10 us
// [R4] Falling gate edge starts when selected
// [R5] Every selected-polarity gate edge restarts the delayed pulse
// [R6] Stop command returns counter to idle
// [R7] Train repeats delay count then pulse count
// [R8] Train starts on arming, no gate
// [R9] Output low in delay, high in pulse
// [R10] Gate level picks count pair in shift
// [R11] Shift mode runs from arming until stop
// [R12] All four counts programmable independently
// [R13] Gate source selectable among legal sources
// [R14] Source pin timebase with chosen edge
// [R15] Sibling terminal count as timebase
// [R16] Host sets parameters before arming
// [R17] Event count increments on source edges
// [R18] Event count starts at zero, counts up
// [R19] Gate edge captures count, counting continues
// [R20] Full capture buffer disarms the counter
// [R21] Falling gate edges capture when selected
// [R22] Event count spans full 24 bits
// [R23] Host reads captures only once disarmed
module gp_counter (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic counter0_gate_pin,
  input wire logic counter0_source_pin,
  input wire logic [1:0] programmable_function_pin,
  // Cascade with the sibling counter
  input wire logic sibling_tc_in,
  output logic terminal_count,
  // Counter output
  output logic counter_out
);
  // Configuration registers
  logic [8:0] ctrl_q, ctrl_d;
  logic [23:0] cnt_q [4];
  logic [23:0] cnt_d [4];
  logic [3:0] caplen_q, caplen_d; // Captures minus one
  logic [31:0] prdata_q, prdata_d;
  // Counter state
  gpc_pkg::state_e st_q, st_d;
  logic [23:0] ctr_q, ctr_d; // Running count
  logic [3:0] idx_q, idx_d; // Next capture slot
  logic out_q, out_d;
  logic tc_q, tc_d;
  logic gate_prev_q, gate_prev_d;
  logic src_prev_q, src_prev_d;
  logic [23:0] cap_mem [`GPC_CAP_DEPTH]; // Capture buffer
  // Decoded controls and events
  logic wr_en, rd_setup, mapped, cmd_wr;
  logic arm_cmd, prep_cmd, stop_cmd, go_cmd;
  logic gate_lvl, gate_edge, src_lvl, src_edge, tick, slow_en, cap_we;
  logic gate_pin_s, src_pin_s, fn0_s, fn1_s;
  logic out_inv, armed;
  logic [23:0] dly_cnt, pls_cnt, arm_ctr;
  gpc_pkg::state_e arm_st;
  gpc_pkg::mode_e mode;
  gpc_pkg::timebase_e tbase;
  gpc_pkg::gate_e gsel;
  logic [31:0] rd_word;

  // Synchronise every pin before use
  pin_sync u_sync_gate (.pclk(pclk), .presetn(presetn), .pin(counter0_gate_pin),
    .level(gate_pin_s));
  pin_sync u_sync_src (.pclk(pclk), .presetn(presetn), .pin(counter0_source_pin),
    .level(src_pin_s));
  pin_sync u_sync_fn0 (.pclk(pclk), .presetn(presetn), .pin(programmable_function_pin[0]),
    .level(fn0_s));
  pin_sync u_sync_fn1 (.pclk(pclk), .presetn(presetn), .pin(programmable_function_pin[1]),
    .level(fn1_s));

  // Slow internal timebase enable
  tick_divider u_slow (.pclk(pclk), .presetn(presetn), .tick(slow_en));

  // Field views
  assign mode = gpc_pkg::mode_e'(ctrl_q[`GPC_CTRL_MODE]);
  assign tbase = gpc_pkg::timebase_e'(ctrl_q[`GPC_CTRL_TB]);
  assign gsel = gpc_pkg::gate_e'(ctrl_q[`GPC_CTRL_GATE]);
  assign out_inv = ctrl_q[`GPC_CTRL_OUT_INV];
  assign armed = (st_q == gpc_pkg::st_wait) || (st_q == gpc_pkg::st_delay) ||
    (st_q == gpc_pkg::st_pulse) || (st_q == gpc_pkg::st_count);

  // APB decode: zero wait states, read data latched in setup
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr[1:0] == 2'h0) &&
    ((paddr <= `GPC_OFF_CAPLEN) || (paddr >= `GPC_OFF_CAPBUF && paddr <= `GPC_OFF_CAPEND));
  assign cmd_wr = wr_en && (paddr == `GPC_OFF_CMD);
  assign arm_cmd = cmd_wr && pwdata[`GPC_CMD_LOAD_ARM];
  assign prep_cmd = cmd_wr && pwdata[`GPC_CMD_LOAD_ONLY];
  assign stop_cmd = cmd_wr && pwdata[`GPC_CMD_STOP];
  assign go_cmd = cmd_wr && pwdata[`GPC_CMD_ARM];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // Gate and timebase selection with edge detection
  always_comb
  begin
    unique case (gsel) // R13
      gpc_pkg::gate_from_pin: gate_lvl = gate_pin_s;
      gpc_pkg::gate_from_fn0: gate_lvl = fn0_s;
      gpc_pkg::gate_from_fn1: gate_lvl = fn1_s;
      gpc_pkg::gate_from_sibling: gate_lvl = sibling_tc_in;
    endcase
    src_lvl = src_pin_s;
    // Falling edge when the falling-active gate setting is on
    gate_edge = ctrl_q[`GPC_CTRL_GATE_FALL] ? (gate_prev_q && !gate_lvl) // R4
      : (!gate_prev_q && gate_lvl);
    src_edge = ctrl_q[`GPC_CTRL_TB_FALL] ? (src_prev_q && !src_lvl) // R14
      : (!src_prev_q && src_lvl);
    gate_prev_d = gate_lvl;
    src_prev_d = src_lvl;
    unique case (tbase)
      gpc_pkg::fast_internal_timebase: tick = 1'b1; // R2
      gpc_pkg::slow_internal_timebase: tick = slow_en; // R3
      gpc_pkg::source_pin_timebase: tick = src_edge; // R14
      gpc_pkg::sibling_terminal_count: tick = sibling_tc_in; // R15
    endcase
  end

  // Count pair chosen by gate level in shift mode
  always_comb
  begin
    if (mode == gpc_pkg::frequency_shift_mode && gate_lvl)
    begin
      dly_cnt = cnt_q[2]; // R10
      pls_cnt = cnt_q[3];
    end
    else
    begin
      dly_cnt = cnt_q[0]; // R7
      pls_cnt = cnt_q[1];
    end
  end

  // Where arming leads in each mode
  always_comb
  begin
    unique case (mode)
      gpc_pkg::retriggerable_pulse_mode:
      begin
        arm_st = gpc_pkg::st_wait;
        arm_ctr = ctr_q;
      end
      gpc_pkg::continuous_train_mode, gpc_pkg::frequency_shift_mode:
      begin
        arm_st = gpc_pkg::st_delay; // R8 R11
        arm_ctr = dly_cnt;
      end
      gpc_pkg::captured_event_count_mode:
      begin
        arm_st = gpc_pkg::st_count;
        arm_ctr = 24'h000000; // R18
      end
    endcase
  end

  // Register writes and read data
  always_comb
  begin
    ctrl_d = ctrl_q;
    cnt_d = cnt_q;
    caplen_d = caplen_q;
    if (wr_en)
    begin
      case (paddr)
        `GPC_OFF_CTRL: ctrl_d = pwdata[8:0];
        `GPC_OFF_CNT1: cnt_d[0] = pwdata[23:0]; // R1
        `GPC_OFF_CNT2: cnt_d[1] = pwdata[23:0];
        `GPC_OFF_CNT3: cnt_d[2] = pwdata[23:0]; // R12
        `GPC_OFF_CNT4: cnt_d[3] = pwdata[23:0];
        `GPC_OFF_CAPLEN: caplen_d = pwdata[3:0];
        default: ctrl_d = ctrl_q; // Read-only or command words
      endcase
    end
    rd_word = 32'h00000000;
    if (paddr >= `GPC_OFF_CAPBUF && mapped)
      rd_word = {8'h00, cap_mem[paddr[5:2]]}; // R23
    else
    begin
      case (paddr)
        `GPC_OFF_CTRL: rd_word = {23'h000000, ctrl_q};
        `GPC_OFF_CNT1: rd_word = {8'h00, cnt_q[0]};
        `GPC_OFF_CNT2: rd_word = {8'h00, cnt_q[1]};
        `GPC_OFF_CNT3: rd_word = {8'h00, cnt_q[2]};
        `GPC_OFF_CNT4: rd_word = {8'h00, cnt_q[3]};
        `GPC_OFF_STAT: rd_word = {24'h000000, idx_q, gate_lvl, out_q,
          st_q == gpc_pkg::st_ready, armed};
        `GPC_OFF_NOW: rd_word = {8'h00, ctr_q};
        `GPC_OFF_CAPLEN: rd_word = {28'h0000000, caplen_q};
        default: rd_word = 32'h00000000;
      endcase
    end
    prdata_d = rd_setup ? rd_word : prdata_q;
  end

  // Register the configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `GPC_CTRL_RST;
      cnt_q[0] <= `GPC_CNT1_RST;
      cnt_q[1] <= `GPC_CNT2_RST;
      cnt_q[2] <= `GPC_CNT3_RST;
      cnt_q[3] <= `GPC_CNT4_RST;
      caplen_q <= `GPC_CAPLEN_RST;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      caplen_q <= caplen_d;
      prdata_q <= prdata_d;
    end
  end

  // Counter sequencing
  always_comb
  begin
    st_d = st_q;
    ctr_d = ctr_q;
    idx_d = idx_q;
    cap_we = 1'b0;
    tc_d = 1'b0;
    if (stop_cmd)
    begin
      st_d = gpc_pkg::st_idle; // R6
      idx_d = 4'h0;
    end
    else
    begin
      unique case (st_q)
        gpc_pkg::st_idle:
        begin
          // Arming while armed is ignored; stop first
          if (arm_cmd)
          begin
            st_d = arm_st;
            ctr_d = arm_ctr;
            idx_d = 4'h0;
          end
          else if (prep_cmd)
            st_d = gpc_pkg::st_ready;
        end
        gpc_pkg::st_ready:
        begin
          if (arm_cmd || go_cmd)
          begin
            st_d = arm_st;
            ctr_d = arm_ctr;
            idx_d = 4'h0;
          end
        end
        gpc_pkg::st_wait:
        begin
          if (gate_edge)
          begin
            st_d = gpc_pkg::st_delay; // R5
            ctr_d = dly_cnt;
          end
        end
        gpc_pkg::st_delay, gpc_pkg::st_pulse:
        begin
          if (mode == gpc_pkg::retriggerable_pulse_mode && gate_edge)
          begin
            // Each selected-polarity gate edge restarts the delay, even mid-pulse
            st_d = gpc_pkg::st_delay; // R5
            ctr_d = dly_cnt;
          end
          else if (tick && ctr_q <= 24'h000001)
          begin
            // Phase of N ticks ends; delay hands over to pulse, pulse to delay or, when retriggerable, to wait
            tc_d = 1'b1;
            if (st_q == gpc_pkg::st_delay)
            begin
              st_d = gpc_pkg::st_pulse; // R7
              ctr_d = pls_cnt;
            end
            else
            begin
              st_d = (mode == gpc_pkg::retriggerable_pulse_mode) ? gpc_pkg::st_wait
                : gpc_pkg::st_delay; // R8 R11
              ctr_d = dly_cnt;
            end
          end
          else if (tick)
            ctr_d = ctr_q - 24'h000001;
        end
        gpc_pkg::st_count:
        begin
          if (tick)
            ctr_d = ctr_q + 24'h000001; // R17 R22
          if (gate_edge)
          begin
            // Capture the count as it stands; counting goes on
            cap_we = 1'b1; // R19 R21
            idx_d = idx_q + 4'h1;
            if (idx_q == caplen_q)
              st_d = gpc_pkg::st_idle; // R20
          end
        end
        default: st_d = gpc_pkg::st_idle; // Illegal code recovers
      endcase
    end
    out_d = (st_d == gpc_pkg::st_pulse) ^ out_inv; // R9
  end

  // Register the counter state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= gpc_pkg::st_idle;
      ctr_q <= 24'h000000;
      idx_q <= 4'h0;
      out_q <= 1'b0;
      tc_q <= 1'b0;
      gate_prev_q <= 1'b0;
      src_prev_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ctr_q <= ctr_d;
      idx_q <= idx_d;
      out_q <= out_d;
      tc_q <= tc_d;
      gate_prev_q <= gate_prev_d;
      src_prev_q <= src_prev_d;
    end
  end

  // Capture buffer storage, no reset needed
  always_ff @(posedge pclk)
  begin
    if (cap_we)
      cap_mem[idx_q] <= ctr_q; // R19
  end

  assign counter_out = out_q;
  assign terminal_count = tc_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stop_idles: assert property (stop_cmd |=> !armed && !counter_out ^ out_inv) // R6
    else $error("stop did not idle the counter");
  a_retrig_edge: assert property (armed && mode == gpc_pkg::retriggerable_pulse_mode
    && gate_edge && !stop_cmd |=> st_q == gpc_pkg::st_delay && ctr_q == $past(dly_cnt)) // R5
    else $error("gate edge did not restart the delay");
  a_pulse_level: assert property (st_q == gpc_pkg::st_pulse && $stable(ctrl_q)
    |-> counter_out == !out_inv) // R9
    else $error("output wrong during pulse phase");
  a_train_starts: assert property (arm_cmd && st_q == gpc_pkg::st_idle
    && mode == gpc_pkg::continuous_train_mode && !stop_cmd
    |=> st_q == gpc_pkg::st_delay ##1 st_q == gpc_pkg::st_delay) // R8
    else $error("train did not start on arming");
  a_train_reload: assert property (st_q == gpc_pkg::st_delay && tick && ctr_q == 24'h000001
    && !stop_cmd && mode == gpc_pkg::continuous_train_mode
    |=> st_q == gpc_pkg::st_pulse && ctr_q == $past(cnt_q[1]) && terminal_count) // R7
    else $error("delay phase did not hand over to pulse");
  a_fsk_pair: assert property (st_q == gpc_pkg::st_pulse && tick && ctr_q == 24'h000001
    && !stop_cmd && mode == gpc_pkg::frequency_shift_mode
    |=> ctr_q == ($past(gate_lvl) ? $past(cnt_q[2]) : $past(cnt_q[0]))) // R10
    else $error("shift mode loaded the wrong count");
  a_slow_hold: assert property (st_q == gpc_pkg::st_delay && tbase ==
    gpc_pkg::slow_internal_timebase && !slow_en && !stop_cmd && !gate_edge
    |=> $stable(ctr_q)) // R3
    else $error("count moved without slow tick");
  a_count_zero: assert property (arm_cmd && st_q == gpc_pkg::st_idle && !stop_cmd
    && mode == gpc_pkg::captured_event_count_mode |=> ctr_q == 24'h000000) // R18
    else $error("event count did not start at zero");
  a_count_step: assert property (st_q == gpc_pkg::st_count && tick && !stop_cmd
    |=> ctr_q == $past(ctr_q) + 24'h000001) // R17
    else $error("event count did not advance");
  a_cap_value: assert property (cap_we |=> cap_mem[$past(idx_q)] == $past(ctr_q)) // R19
    else $error("captured value wrong");
  a_cap_disarm: assert property (st_q == gpc_pkg::st_count && gate_edge && !stop_cmd
    && idx_q == caplen_q |=> !armed [*2]) // R20
    else $error("full buffer did not disarm");

  c_retrig_mid: cover property (st_q == gpc_pkg::st_pulse && gate_edge
    && mode == gpc_pkg::retriggerable_pulse_mode);
  c_fsk_high: cover property (st_q == gpc_pkg::st_pulse && gate_lvl
    && mode == gpc_pkg::frequency_shift_mode);
  c_cap_full: cover property (st_q == gpc_pkg::st_count ##1 st_q == gpc_pkg::st_idle);
endmodule : gp_counter

// file: shared/gpc_cfg.svh
// Register map, field positions, reset values and timing counts of the counter
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// Register byte offsets
`define GPC_OFF_CTRL 8'h00
`define GPC_OFF_CMD 8'h04
`define GPC_OFF_CNT1 8'h08
`define GPC_OFF_CNT2 8'h0C
`define GPC_OFF_CNT3 8'h10
`define GPC_OFF_CNT4 8'h14
`define GPC_OFF_STAT 8'h18
`define GPC_OFF_NOW 8'h1C
`define GPC_OFF_CAPLEN 8'h20
`define GPC_OFF_CAPBUF 8'h40
`define GPC_OFF_CAPEND 8'h7C

// Control register fields
`define GPC_CTRL_MODE 1:0
`define GPC_CTRL_TB 3:2
`define GPC_CTRL_TB_FALL 4
`define GPC_CTRL_GATE 6:5
`define GPC_CTRL_GATE_FALL 7
`define GPC_CTRL_OUT_INV 8
`define GPC_CTRL_RST 9'h000

// Command register bits
`define GPC_CMD_LOAD_ARM 0
`define GPC_CMD_LOAD_ONLY 1
`define GPC_CMD_STOP 2
`define GPC_CMD_ARM 3

// Count reset values (5, 10, 4 and 6 million ticks)
`define GPC_CNT1_RST 24'h4C4B40
`define GPC_CNT2_RST 24'h989680
`define GPC_CNT3_RST 24'h3D0900
`define GPC_CNT4_RST 24'h5B8D80
`define GPC_CAPLEN_RST 4'hF
`define GPC_CAP_DEPTH 16

// Timing: clock period and slow timebase period in ns
`define GPC_CLK_PERIOD_NS 50
`define GPC_SLOW_PERIOD_NS 10000
`define GPC_SLOW_DIV (`GPC_SLOW_PERIOD_NS / `GPC_CLK_PERIOD_NS)

`endif

// file: shared/gpc_pkg.sv
// Types shared by the counter design files
package gpc_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    retriggerable_pulse_mode = 2'h0,
    continuous_train_mode = 2'h1,
    frequency_shift_mode = 2'h2,
    captured_event_count_mode = 2'h3
  } mode_e;
  // Timebase choices
  typedef enum logic [1:0] {
    fast_internal_timebase = 2'h0,
    slow_internal_timebase = 2'h1,
    source_pin_timebase = 2'h2,
    sibling_terminal_count = 2'h3
  } timebase_e;
  // Gate choices
  typedef enum logic [1:0] {
    gate_from_pin = 2'h0,
    gate_from_fn0 = 2'h1,
    gate_from_fn1 = 2'h2,
    gate_from_sibling = 2'h3
  } gate_e;
  // Counter states, Gray along idle-wait-delay-pulse
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_wait = 3'h1,
    st_delay = 3'h3,
    st_pulse = 3'h2,
    st_count = 3'h6,
    st_ready = 3'h4
  } state_e;
endpackage : gpc_pkg

// file: hdl/pin_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/1ns
module pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and its synchronised level
  input wire logic pin,
  output logic level
);
  logic meta_q; // First stage, read only by sync_q
  logic sync_q; // Second stage

  // Shift the pin through two stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign level = sync_q;
endmodule : pin_sync

// file: hdl/tick_divider.sv
// Divider giving the one-cycle enable of the slow internal timebase
`timescale 1ns/1ns
`include "gpc_cfg.svh"
module tick_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Slow timebase enable
  output logic tick
);
  localparam logic [7:0] LAST = 8'(`GPC_SLOW_DIV - 1);
  logic [7:0] div_q, div_d; // Free-running divide count
  logic tick_q, tick_d; // Registered enable

  // Wrap at the last count
  always_comb
  begin
    div_d = (div_q == LAST) ? 8'h00 : div_q + 8'h01;
    tick_d = (div_q == LAST);
  end

  // Register the divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : tick_divider

// file: verification/apb_host_model.sv
// APB host model that configures, arms and reads back the counter
`timescale 1ns/1ns
module apb_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end

  // One transfer; waits for pready, never assumes a latency
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never pass as valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host_model

// file: verification/gp_counter_pulse_fsk_event_bench.sv
// Self-checking bench for the general-purpose counter
`timescale 1ns/1ns
`include "gpc_cfg.svh"
module gp_counter_pulse_fsk_event_bench;
  // Clock, reset and APB wires
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Pins driven by the bench
  logic gate_pin = 1'b0;
  logic src_pin = 1'b0;
  logic [1:0] fn_pins = 2'h0;
  logic sib_tc = 1'b0;
  // Observed outputs
  logic tc;
  logic cnt_out;
  // Scoreboard and watchdog
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 20 MHz clock
  always #25 pclk = ~pclk;

  apb_host_model host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  gp_counter uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter0_gate_pin(gate_pin),
    .counter0_source_pin(src_pin), .programmable_function_pin(fn_pins),
    .sibling_tc_in(sib_tc), .terminal_count(tc), .counter_out(cnt_out));

  // Verdict and end of run
  task test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Watchdog; the whole run needs well under this
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  // Word compare
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  // Length compare, in clock cycles
  task automatic chk_len(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_len

  // Register access helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    host.xfer(a, 1'b0, 32'h0, q, e);
  endtask : rd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    rd(a, q, e);
    chk_word(what, exp, q);
  endtask : rd_chk

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step

  // Length of the next run of the given output level
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (cnt_out !== lvl) @(posedge pclk);
    while (cnt_out === lvl)
    begin
      n++;
      @(posedge pclk);
    end
  endtask : run_len

  // Expected phase length: slow timebase stretches each tick
  function automatic int exp_len(input int n, input logic slow);
    return slow ? n * `GPC_SLOW_DIV : n;
  endfunction : exp_len

  // Control word; timebase edge rising, output not inverted
  function automatic logic [31:0] ctrl_word(input logic [1:0] md, input logic [1:0] tb,
    input logic [1:0] gs, input logic gf);
    return {24'h000000, gf, gs, 1'b0, tb, md};
  endfunction : ctrl_word

  // Drive the selected gate pin; the sibling gate setting drives the gate pin instead
  task automatic gate_drive(input logic [1:0] gs, input logic v);
    if (gs == 2'h1)
      fn_pins[0] <= v;
    else if (gs == 2'h2)
      fn_pins[1] <= v;
    else
      gate_pin <= v;
  endtask : gate_drive

  // Captured event counting with three captures
  task automatic ev_run(input logic [1:0] tb, input logic [1:0] gs, input logic gf);
    logic [23:0] cap [3];
    logic [31:0] q;
    logic e;
    int acc;
    int k;
    acc = 0;
    gate_drive(gs, gf);
    wr(`GPC_OFF_CMD, 32'h4);
    wr(`GPC_OFF_CTRL, ctrl_word(2'h3, tb, gs, gf));
    wr(`GPC_OFF_CAPLEN, 32'h2);
    step(6);
    // Falling-gate run takes the load-only then arm path
    if (gf)
    begin
      wr(`GPC_OFF_CMD, 32'h2);
      rd(`GPC_OFF_STAT, q, e);
      chk_word("ready not armed", 32'h2, {30'h0, q[1:0]});
      wr(`GPC_OFF_CMD, 32'h8);
    end
    else
      wr(`GPC_OFF_CMD, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      k = $urandom_range(5, 1);
      for (int t = 0; t < k; t++)
      begin
        // Sibling counts each high cycle, so it pulses for one cycle only
        if (tb == 2'h3)
        begin
          sib_tc <= 1'b1;
          step(1);
          sib_tc <= 1'b0;
          step(7);
        end
        else
        begin
          src_pin <= 1'b1;
          step(4);
          src_pin <= 1'b0;
          step(4);
        end
      end
      acc += k;
      cap[i] = acc[23:0];
      step(6);
      gate_drive(gs, ~gf);
      step(6);
      gate_drive(gs, gf);
      step(6);
    end
    rd(`GPC_OFF_STAT, q, e);
    chk_word("armed after fill", 32'h0, {31'h0, q[0]});
    // Captures read only once disarmed
    for (int i = 0; i < 3; i++)
    begin
      rd_chk("capture", `GPC_OFF_CAPBUF + 8'(4 * i), {8'h00, cap[i]});
    end
  endtask : ev_run

  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic e;
    int c [4];
    int h;
    int l;
    int x;
    void'($urandom(59));
    step(5);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    rd_chk("ctrl", `GPC_OFF_CTRL, 32'h0);
    rd_chk("cnt1", `GPC_OFF_CNT1, {8'h00, `GPC_CNT1_RST});
    rd_chk("cnt2", `GPC_OFF_CNT2, {8'h00, `GPC_CNT2_RST});
    rd_chk("cnt3", `GPC_OFF_CNT3, {8'h00, `GPC_CNT3_RST});
    rd_chk("cnt4", `GPC_OFF_CNT4, {8'h00, `GPC_CNT4_RST});
    rd_chk("caplen", `GPC_OFF_CAPLEN, {28'h0, `GPC_CAPLEN_RST});
    rd(8'h24, q, e);
    chk_word("unmapped err", 32'h1, {31'h0, e});
    chk_word("unmapped data", 32'h0, q);
    q = $urandom;
    wr(`GPC_OFF_CNT4, q);
    rd_chk("cnt4 wide", `GPC_OFF_CNT4, {8'h00, q[23:0]});
    // Pulse train on the fast timebase, no gate event
    c[0] = $urandom_range(9, 2);
    c[1] = $urandom_range(9, 2);
    wr(`GPC_OFF_CTRL, ctrl_word(2'h1, 2'h0, 2'h0, 1'b0));
    wr(`GPC_OFF_CNT1, 32'(c[0]));
    wr(`GPC_OFF_CNT2, 32'(c[1]));
    wr(`GPC_OFF_CMD, 32'h1);
    run_len(1'b0, x);
    run_len(1'b1, h);
    run_len(1'b0, l);
    chk_len("train high", exp_len(c[1], 1'b0), h);
    chk_len("train low", exp_len(c[0], 1'b0), l);
    // Any window of one period holds exactly two phase ends
    x = 0;
    repeat (c[0] + c[1])
    begin
      @(posedge pclk);
      x += int'(tc === 1'b1);
    end
    chk_len("phase ends per period", 2, x);
    wr(`GPC_OFF_CMD, 32'h4);
    step(4);
    chk_word("stopped out", 32'h0, {31'h0, cnt_out});
    rd(`GPC_OFF_STAT, q, e);
    chk_word("stopped armed", 32'h0, {31'h0, q[0]});
    // Slow timebase, counts of two
    wr(`GPC_OFF_CTRL, ctrl_word(2'h1, 2'h1, 2'h0, 1'b0));
    wr(`GPC_OFF_CNT1, 32'h2);
    wr(`GPC_OFF_CNT2, 32'h2);
    wr(`GPC_OFF_CMD, 32'h1);
    run_len(1'b0, x);
    run_len(1'b1, h);
    chk_len("slow high", exp_len(2, 1'b1), h);
    wr(`GPC_OFF_CMD, 32'h4);
    // Frequency shift with four distinct counts
    for (int i = 0; i < 4; i++)
    begin
      c[i] = $urandom_range(3 * i + 4, 3 * i + 2);
    end
    wr(`GPC_OFF_CTRL, ctrl_word(2'h2, 2'h0, 2'h0, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      wr(`GPC_OFF_CNT1 + 8'(4 * i), 32'(c[i]));
    end
    wr(`GPC_OFF_CMD, 32'h1);
    run_len(1'b0, x);
    run_len(1'b1, h);
    run_len(1'b0, l);
    chk_len("shift low gate high", c[1], h);
    chk_len("shift low gate low", c[0], l);
    gate_pin <= 1'b1;
    step(5);
    run_len(1'b0, x);
    run_len(1'b1, h);
    run_len(1'b0, l);
    chk_len("shift high gate high", c[3], h);
    chk_len("shift high gate low", c[2], l);
    wr(`GPC_OFF_CMD, 32'h4);
    // Retriggerable pulse on falling gate edges
    wr(`GPC_OFF_CTRL, ctrl_word(2'h0, 2'h0, 2'h0, 1'b1));
    wr(`GPC_OFF_CNT1, 32'h3);
    wr(`GPC_OFF_CNT2, 32'hC);
    wr(`GPC_OFF_CMD, 32'h1);
    step(4);
    gate_pin <= 1'b0;
    run_len(1'b1, h);
    chk_len("retrig high", 12, h);
    gate_pin <= 1'b1;
    x = 0;
    repeat (40)
    begin
      @(posedge pclk);
      x += int'(cnt_out === 1'b1);
    end
    chk_len("rising ignored", 0, x);
    gate_pin <= 1'b0;
    run_len(1'b0, x);
    step(2);
    gate_pin <= 1'b1;
    step(3);
    gate_pin <= 1'b0;
    run_len(1'b1, x);
    run_len(1'b0, l);
    run_len(1'b1, h);
    chk_len("retrig delay", 3, l);
    chk_len("retrig pulse", 12, h);
    // Event capture: pin timebase with alternate gate, then sibling timebase
    ev_run(2'h2, 2'h1, 1'b0);
    ev_run(2'h3, 2'h2, 1'b1);
    test_done();
  end
endmodule : gp_counter_pulse_fsk_event_bench
